// ==== src/aspc_core.sv ====
// angle sensor digital core: sampling, filter, direction, zero, power modes
`timescale 1ns/10ps
`include "aspc_defs.svh"
module aspc_core import aspc_pkg::*; #(
    parameter int WIDTH = 16,
    parameter int FW_BITS = 4,
    parameter int PER_BITS = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic enable_pin_i,
    input wire logic auto_sample_cycle_pin_i,
    input wire logic pins_override_i,
    input wire logic [1:0] mode_cfg_i,
    input wire logic [FW_BITS-1:0] filter_window_i,
    input wire logic reverse_dir_i,
    input wire logic [WIDTH-1:0] zero_angle_i,
    input wire logic [PER_BITS-1:0] active_time_i,
    input wire logic [PER_BITS-1:0] cycle_period_i,
    input wire logic [WIDTH-1:0] raw_angle_i,
    output logic [WIDTH-1:0] angle_o,
    output logic front_end_on_o,
    output logic data_valid_o,
    output logic [1:0] mode_o
);
    localparam int SDIV = `ASPC_SAMPLE_DIV;
    localparam int LDIV = `ASPC_LP_DIV;
    localparam int SUCYC = `ASPC_STARTUP_CYC;
    if (WIDTH < 8 || PER_BITS < 2 || SDIV < 2 || SDIV > 256 || LDIV < 2 || LDIV > 65536
        || SUCYC < 1 || SUCYC > 65535) begin : g_bad_params
        $error("aspc_core: bad parameters");
    end
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: pins come from the master's domain
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    always_ff @(posedge clk_i) begin
        // reset low: a chip select never driven high must not release the preset mode
        if (rst_i) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
        end else begin
            pin_s1 <= {cs_n_i, enable_pin_i, auto_sample_cycle_pin_i};
            pin_s2 <= pin_s1;
        end
    end
    logic cs_n_s;
    logic en_s;
    logic asc_s;
    assign cs_n_s = pin_s2[2];
    assign en_s = pin_s2[1];
    assign asc_s = pin_s2[0];
    function automatic aspc_mode_e decode_mode(input logic en, input logic auto_sample_cycle);
        if (auto_sample_cycle) begin
            return ASPC_MODE_CYCLE;
        end else if (en) begin
            return ASPC_MODE_ACTIVE;
        end
        return ASPC_MODE_IDLE;
    endfunction
    aspc_mode_e sel_mode;
    always_comb begin
        if (pins_override_i) begin
            sel_mode = decode_mode(en_s, asc_s); // RL13
        end else begin
            sel_mode = aspc_mode_e'(mode_cfg_i);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // dividers: sample tick and low-power tick
    logic [7:0] sdiv_cnt;
    logic [15:0] ldiv_cnt;
    logic [7:0] next_sdiv_cnt;
    logic [15:0] next_ldiv_cnt;
    logic sample_tick;
    logic lp_tick;
    always_comb begin
        sample_tick = (sdiv_cnt == 8'(SDIV - 1));
        lp_tick = (ldiv_cnt == 16'(LDIV - 1));
        next_sdiv_cnt = sample_tick ? 8'h00 : sdiv_cnt + 8'h01; // RL1
        next_ldiv_cnt = lp_tick ? 16'h0000 : ldiv_cnt + 16'h0001; // RL9
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdiv_cnt <= 8'h00;
            ldiv_cnt <= 16'h0000;
        end else begin
            sdiv_cnt <= next_sdiv_cnt;
            ldiv_cnt <= next_ldiv_cnt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // power state machine
    aspc_state_e state;
    aspc_state_e next_state;
    logic [PER_BITS-1:0] cyc_cnt;
    logic [PER_BITS-1:0] next_cyc_cnt;
    logic [15:0] su_cnt;
    logic [15:0] next_su_cnt;
    logic fe_on;
    logic valid;
    logic next_valid;
    logic load_out;
    logic first_sample;
    always_comb begin
        next_state = state;
        next_cyc_cnt = cyc_cnt;
        next_su_cnt = su_cnt;
        next_valid = valid;
        load_out = 1'b0;
        case (state)
            ASPC_ST_WAIT_CS: begin
                if (cs_n_s) begin
                    next_state = ASPC_ST_IDLE; // RL17
                end
            end
            ASPC_ST_IDLE: begin
                if (sel_mode == ASPC_MODE_ACTIVE) begin
                    next_state = ASPC_ST_ACTIVE;
                    next_su_cnt = 16'h0000;
                end else if (sel_mode == ASPC_MODE_CYCLE) begin
                    if (lp_tick) begin
                        next_cyc_cnt = cyc_cnt + 1'b1;
                    end
                    if (lp_tick && cyc_cnt + 1'b1 >= cycle_period_i) begin
                        next_state = ASPC_ST_ACTIVE; // RL8
                        next_cyc_cnt = '0;
                        next_su_cnt = 16'h0000;
                    end
                end
            end
            ASPC_ST_ACTIVE: begin
                if (su_cnt != 16'(SUCYC)) begin
                    next_su_cnt = su_cnt + 16'h0001;
                end else begin
                    next_valid = 1'b1; // RL16
                end
                if (sel_mode == ASPC_MODE_IDLE) begin
                    next_state = ASPC_ST_IDLE; // RL3
                end else if (sel_mode == ASPC_MODE_CYCLE) begin
                    if (lp_tick) begin
                        next_cyc_cnt = cyc_cnt + 1'b1;
                    end
                    if (lp_tick && cyc_cnt + 1'b1 >= active_time_i) begin
                        next_state = ASPC_ST_IDLE; // RL9
                        load_out = 1'b1; // RL11
                        next_valid = 1'b1;
                    end
                end else begin
                    next_cyc_cnt = '0;
                    load_out = sample_tick; // RL7
                end
            end
            default: begin
                next_state = ASPC_ST_WAIT_CS;
            end
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ASPC_ST_WAIT_CS;
            cyc_cnt <= '0;
            su_cnt <= 16'h0000;
            valid <= 1'b0;
        end else begin
            state <= next_state;
            cyc_cnt <= next_cyc_cnt;
            su_cnt <= next_su_cnt;
            valid <= next_valid;
        end
    end
    assign fe_on = (state == ASPC_ST_ACTIVE);
    assign first_sample = fe_on && (su_cnt == 16'h0000);
    ////////////////////////////////////////////////////////////////////////////
    // filter only clocks its state while active; idle leaves it frozen
    logic [WIDTH-1:0] filt;
    aspc_filter #(
        .WIDTH(WIDTH),
        .FW_BITS(FW_BITS)
    ) u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(fe_on),
        .load_i(first_sample),
        .sample_i(sample_tick),
        .data_i(raw_angle_i),
        .filter_window_i(filter_window_i),
        .data_o(filt)
    );
    ////////////////////////////////////////////////////////////////////////////
    // direction and zero; modulo wrap gives one turn per electrical period
    logic [WIDTH-1:0] oriented;
    logic [WIDTH-1:0] corrected;
    always_comb begin
        oriented = reverse_dir_i ? WIDTH'(~filt + 1'b1) : filt; // RL5 RL6
        corrected = oriented - zero_angle_i; // RL6 RL14
    end
    ////////////////////////////////////////////////////////////////////////////
    // output buffer, frozen while chip select is low
    logic [WIDTH-1:0] out_buf;
    logic [WIDTH-1:0] next_out_buf;
    logic [1:0] next_mode;
    always_comb begin
        next_out_buf = out_buf;
        if (load_out && cs_n_s) begin
            next_out_buf = corrected; // RL15 RL12 RL10
        end
        next_mode = 2'(sel_mode);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_buf <= '0;
            angle_o <= '0;
            front_end_on_o <= 1'b0;
            data_valid_o <= 1'b0;
            mode_o <= 2'h0;
        end else begin
            out_buf <= next_out_buf; // RL4
            angle_o <= next_out_buf;
            front_end_on_o <= (next_state == ASPC_ST_ACTIVE);
            data_valid_o <= next_valid;
            mode_o <= next_mode;
        end
    end
endmodule

// ==== src/aspc_defs.svh ====
// constants for the angle sensor power cycling block
// Summary of operation
// [RL1] new angle sample at one megahertz
// [RL2] first-order low-pass filter, window sets constant
// [RL3] idle stops sampling and filter, output kept
// [RL4] idle keeps configuration and interface logic alive
// [RL5] default direction: angle rises clockwise
// [RL6] configurable direction reversal and zero offset
// [RL7] active mode samples and filters continuously
// [RL8] cycle mode alternates active and idle itself
// [RL9] low-power tick times active and period
// [RL10] cycle mode refresh equals cycle period; the core refreshes every cycle_period_i low-power ticks while cycle_period_i exceeds active_time_i
// [RL11] cycle mode output updates at active end
// [RL12] reads in cycle mode behave as active
// [RL13] enable and cycle pins select power mode
// [RL14] one output turn per electrical period
// [RL15] chip select low freezes output buffer
// [RL16] valid data within 35 us after activation
// [RL17] preset mode starts after chip select high
`ifndef ASPC_DEFS_SVH
`define ASPC_DEFS_SVH
`define ASPC_CLK_HZ 25000000
`define ASPC_SAMPLE_HZ 1000000
`define ASPC_SAMPLE_DIV (`ASPC_CLK_HZ / `ASPC_SAMPLE_HZ)
`define ASPC_LP_HZ 100000
`define ASPC_LP_DIV (`ASPC_CLK_HZ / `ASPC_LP_HZ)
`define ASPC_STARTUP_NS 35000
`define ASPC_STARTUP_CYC ((`ASPC_STARTUP_NS * (`ASPC_CLK_HZ / 1000000)) / 1000)
`define ASPC_FW_MAX 15
`endif

// ==== src/aspc_pkg.sv ====
// types for the angle sensor power cycling block
package aspc_pkg;
    typedef enum logic [1:0] {
        ASPC_MODE_IDLE,
        ASPC_MODE_ACTIVE,
        ASPC_MODE_CYCLE
    } aspc_mode_e;
    typedef enum logic [1:0] {
        ASPC_ST_WAIT_CS,
        ASPC_ST_IDLE,
        ASPC_ST_ACTIVE
    } aspc_state_e;
endpackage

// ==== src/aspc_filter.sv ====
// first-order low-pass filter with shift-selected time constant
`timescale 1ns/10ps
module aspc_filter #(
    parameter int WIDTH = 16,
    parameter int FW_BITS = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic load_i,
    input wire logic sample_i,
    input wire logic [WIDTH-1:0] data_i,
    input wire logic [FW_BITS-1:0] filter_window_i,
    output logic [WIDTH-1:0] data_o
);
    localparam int ACC_W = WIDTH + (1 << FW_BITS);
    if (WIDTH < 2 || FW_BITS < 1 || FW_BITS > 4) begin : g_bad_params
        $error("aspc_filter: bad parameters");
    end
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic [WIDTH:0] diff;
    logic [ACC_W-1:0] step;
    ////////////////////////////////////////////////////////////////////////////
    // circular difference keeps the wrap at full turn from dragging the average
    always_comb begin
        diff = {1'b0, data_i} - {1'b0, acc[ACC_W-1 -: WIDTH]};
        // larger window, larger step: the top setting halves the error each sample
        step = ACC_W'({{(ACC_W-WIDTH){diff[WIDTH-1]}}, diff[WIDTH-1:0]} << filter_window_i);
        next_acc = acc;
        if (load_i) begin
            next_acc = {data_i, {(ACC_W-WIDTH){1'b0}}};
        end else if (en_i && sample_i) begin
            next_acc = acc + step; // RL2
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end
    assign data_o = acc[ACC_W-1 -: WIDTH];
endmodule

// ==== testbench/aspc_core_props.sv ====
// port checker for the angle sensor core
`timescale 1ns/10ps
module aspc_core_props import aspc_pkg::*; #(
    parameter int WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic enable_pin_i,
    input wire logic auto_sample_cycle_pin_i,
    input wire logic pins_override_i,
    input wire logic [1:0] mode_cfg_i,
    input wire logic [WIDTH-1:0] angle_o,
    input wire logic front_end_on_o,
    input wire logic data_valid_o,
    input wire logic [1:0] mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] last;
    logic [7:0] gap;
    logic [9:0] on_cnt;
    // counters saturate so a long idle never wraps into a false short gap
    always_ff @(posedge clk_i) begin
        last <= angle_o;
        gap <= rst_i ? 8'hff : (angle_o != last) ? 8'h00 : (gap == 8'hff) ? gap : gap + 8'h01;
        on_cnt <= !front_end_on_o ? 10'h000 : (on_cnt == 10'h3ff) ? on_cnt : on_cnt + 10'h001;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_cs_freeze: assert property (!cs_n_i [*4] |=> $stable(angle_o))
        else $error("angle moved while chip select low");
    a_idle_hold: assert property (!front_end_on_o [*3] |=> $stable(angle_o))
        else $error("angle moved with front end off");
    a_idle_off: assert property ((!pins_override_i && mode_cfg_i == 2'h0) [*6]
        |-> !front_end_on_o) else $error("front end on in idle");
    a_active_on: assert property ((cs_n_i && !pins_override_i
        && mode_cfg_i == 2'h1) [*8] |-> front_end_on_o) else $error("front end off in active");
    a_pin_mode: assert property ((pins_override_i && cs_n_i
        && $stable({enable_pin_i, auto_sample_cycle_pin_i})) [*6]
        |-> mode_o == (auto_sample_cycle_pin_i
        ? ASPC_MODE_CYCLE : enable_pin_i ? ASPC_MODE_ACTIVE : ASPC_MODE_IDLE))
        else $error("pin mode not followed");
    a_cfg_mode: assert property ((!pins_override_i && cs_n_i && $stable(mode_cfg_i)) [*6]
        |-> mode_o == mode_cfg_i) else $error("configured mode not followed");
    a_sample_gap: assert property ($changed(angle_o) |-> gap >= 8'h18)
        else $error("angle refreshed faster than sample rate");
    a_valid_time: assert property ($rose(data_valid_o)
        |-> on_cnt inside {[10'h35c:10'h370]}) else $error("data valid at wrong start-up time");
endmodule
bind aspc_core aspc_core_props #(.WIDTH(WIDTH)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .cs_n_i(cs_n_i), .enable_pin_i(enable_pin_i),
    .auto_sample_cycle_pin_i(auto_sample_cycle_pin_i),
    .pins_override_i(pins_override_i), .mode_cfg_i(mode_cfg_i), .angle_o(angle_o),
    .front_end_on_o(front_end_on_o), .data_valid_o(data_valid_o), .mode_o(mode_o));

// ==== testbench/aspc_master.sv ====
// external master model: chip select framing and power mode pins
`timescale 1ns/10ps
module aspc_master (
    input wire logic clk_i,
    output logic cs_n_o,
    output logic enable_pin_o,
    output logic auto_sample_cycle_pin_o
);
    // chip select starts low so the preset mode must wait for it
    initial begin
        cs_n_o = 1'b0;
        enable_pin_o = 1'b0;
        auto_sample_cycle_pin_o = 1'b0;
    end
    task automatic set_pins(input logic en, input logic auto_sample_cycle);
        @(negedge clk_i);
        enable_pin_o = en;
        auto_sample_cycle_pin_o = auto_sample_cycle;
    endtask
    // a read is bracketed by these edges, at any time and in any mode
    task automatic set_cs(input logic lvl);
        @(negedge clk_i);
        cs_n_o = lvl;
    endtask
endmodule

// ==== testbench/tb_aspc_core.sv ====
// self-checking bench for the angle sensor core
`timescale 1ns/10ps
module tb_aspc_core import aspc_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n_i, en_pin, asc_pin, front_end_on_o, data_valid_o;
    logic pins_override_i = 1'b0;
    logic reverse_dir_i = 1'b0;
    logic [1:0] mode_cfg_i = 2'h1;
    logic [1:0] mode_o;
    logic [3:0] filter_window_i = 4'hf;
    logic [15:0] zero_angle_i = 16'h0000;
    logic [15:0] raw_angle_i = 16'h1000;
    logic [15:0] active_time_i = 16'h0004;
    logic [15:0] cycle_period_i = 16'h0006;
    logic [15:0] angle_o, v;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int n, c;
    aspc_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .enable_pin_i(en_pin),
        .auto_sample_cycle_pin_i(asc_pin), .pins_override_i(pins_override_i),
        .mode_cfg_i(mode_cfg_i), .filter_window_i(filter_window_i), .reverse_dir_i(reverse_dir_i),
        .zero_angle_i(zero_angle_i), .active_time_i(active_time_i),
        .cycle_period_i(cycle_period_i), .raw_angle_i(raw_angle_i), .angle_o(angle_o),
        .front_end_on_o(front_end_on_o), .data_valid_o(data_valid_o), .mode_o(mode_o));
    aspc_master u_master (.clk_i(clk_i), .cs_n_o(cs_n_i), .enable_pin_o(en_pin),
        .auto_sample_cycle_pin_o(asc_pin));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d checks %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // whole run is about 4300 cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic wait_change;
        logic [15:0] old;
        old = angle_o;
        n = 0;
        while (angle_o === old && n < 100) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic wait_fe(input logic lvl, output int k);
        k = 0;
        while (front_end_on_o !== lvl && k < 3000) begin
            @(negedge clk_i);
            k++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(8);
        rst_i = 1'b0;
        tick(20);
        check(front_end_on_o, 1'b0);
        u_master.set_cs(1'b1);
        tick(800);
        check(data_valid_o, 1'b0);
        tick(150);
        check(data_valid_o, 1'b1);
        check(front_end_on_o, 1'b1);
        check(angle_o, 16'h1000);
        zero_angle_i = 16'h0400;
        tick(60);
        check(angle_o, 16'h0c00);
        zero_angle_i = 16'h0000;
        reverse_dir_i = 1'b1;
        tick(60);
        check(angle_o, 16'hf000);
        reverse_dir_i = 1'b0;
        tick(60);
        // even steps keep the halving exact, so no rounding guess is needed
        raw_angle_i = 16'h3000;
        wait_change();
        check(angle_o, 16'h2000);
        wait_change();
        check(angle_o, 16'h2800);
        check(16'(n), 16'h0019);
        // one step lower window: a quarter of the remaining error per sample
        filter_window_i = 4'he;
        wait_change();
        check(angle_o, 16'h2c00);
        wait_change();
        check(angle_o, 16'h2d00);
        u_master.set_cs(1'b0);
        tick(4);
        v = angle_o;
        tick(60);
        check(angle_o, v);
        u_master.set_cs(1'b1);
        wait_change();
        check(16'(n < 40), 16'h0001);
        mode_cfg_i = 2'h0;
        tick(10);
        v = angle_o;
        check(front_end_on_o, 1'b0);
        check(mode_o, ASPC_MODE_IDLE);
        raw_angle_i = 16'h5000;
        tick(100);
        check(angle_o, v);
        pins_override_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            u_master.set_pins(i[0], i[1]);
            tick(10);
            check(mode_o, i[1] ? ASPC_MODE_CYCLE
                : i[0] ? ASPC_MODE_ACTIVE : ASPC_MODE_IDLE);
        end
        wait_fe(1'b0, c);
        wait_fe(1'b1, c);
        v = angle_o;
        raw_angle_i = 16'h6000;
        tick(900);
        check(angle_o, v);
        wait_fe(1'b0, c);
        check(16'(c + 900), 16'h03e8);
        tick(5);
        check(angle_o, 16'h6000);
        wait_fe(1'b1, n);
        check(16'(c + 905 + n), 16'h05dc);
        pins_override_i = 1'b0;
        mode_cfg_i = 2'h2;
        tick(10);
        check(mode_o, ASPC_MODE_CYCLE);
        end_sim();
    end
endmodule
